/* asbt_ctrl.sv */
// Host controller that drives a 512K x 8 asynchronous static memory
// Summary of operation
// RULE1: Wait power-up time before first access
// RULE2: Read cycle spaced by minimum read time
// RULE3: Device data valid after select delay
// RULE4: Device data valid after output enable
// RULE5: Device holds old data after address change
// RULE6: Device enters standby when deselected
// RULE7: Address-only reads keep strobes low
// RULE8: Address valid by select falling edge
// RULE9: Write only during select and write overlap
// RULE10: Time data against terminating strobe edge
// RULE11: Address and strobes held minimum before end
// RULE12: Address valid by write start
// RULE13: Address stable until write end
// RULE14: Write data stable before write end
// RULE15: Write data held until terminating edge
// RULE16: Write cycles respect minimum cycle time
// RULE17: Device floats data lines during write
// RULE18: Joint strobe rise keeps outputs floating
// RULE19: Never drive data while device drives
// RULE20: Output disabled select leaves lines floating
// RULE21: Deselect before supply enters retention
// RULE22: Wait recovery time after retention
// RULE23: Read needs select, output enable, write high
// RULE24: Device stores byte at addressed location
// RULE25: Data lines float unless reading
// RULE26: Deselected device ignores all inputs
`timescale 1ns/1ns
module asbt_ctrl
  import asbt_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = ASBT_POWERUP_WAIT_CYC
) (
  // Clock and reset
  input  logic                   clock,
  input  logic                   resetn,
  // User request
  input  logic                   reqValid,
  input  asbt_pkg::asbt_req_s    req,
  output logic                   reqReady,
  // User response
  output logic                   rspValid,
  output logic [ASBT_DATA_W-1:0] rspData,
  // Retention control
  input  logic                   retainReq,
  output logic                   retainAck,
  // Memory pins
  output asbt_pkg::asbt_pins_s   sramPins,
  output logic [ASBT_DATA_W-1:0] dataOut,
  output logic                   dataOe,
  input  logic [ASBT_DATA_W-1:0] dataIn
);

  localparam logic [ASBT_CNT_W-1:0] POWERUP_LAST  = ASBT_CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [ASBT_CNT_W-1:0] RECOVERY_LAST = ASBT_CNT_W'(ASBT_RECOVERY_CYC - 1);
  localparam logic [1:0]            READ_LAST     = 2'(ASBT_READ_HOLD_CYC - 1);

  asbt_state_e            state_reg,     state_next;
  logic [ASBT_CNT_W-1:0]  waitCnt_reg,   waitCnt_next;
  logic [1:0]             readCnt_reg,   readCnt_next;
  asbt_pins_s             pins_reg,      pins_next;
  logic [ASBT_DATA_W-1:0] dataOut_reg,   dataOut_next;
  logic                   dataOe_reg,    dataOe_next;
  logic                   reqReady_reg,  reqReady_next;
  logic                   rspValid_reg,  rspValid_next;
  logic [ASBT_DATA_W-1:0] rspData_reg,   rspData_next;
  logic                   retainAck_reg, retainAck_next;
  logic [ASBT_DATA_W-1:0] dataSync;

  // Pins are asynchronous to the clock
  asbt_sync asbt_sync_i (
    .clock     (clock),
    .resetn    (resetn),
    .dataAsync (dataIn),
    .dataSync  (dataSync)
  );

  always_comb begin
    state_next     = state_reg;
    waitCnt_next   = waitCnt_reg;
    readCnt_next   = readCnt_reg;
    pins_next      = pins_reg;
    dataOut_next   = dataOut_reg;
    dataOe_next    = dataOe_reg;
    rspValid_next  = 1'b0;
    rspData_next   = rspData_reg;
    retainAck_next = retainAck_reg;
    unique case (state_reg)
      ST_POWERUP: begin
        waitCnt_next = waitCnt_reg + 13'h0001;
        if (waitCnt_reg == POWERUP_LAST) begin // [RULE1]
          state_next   = ST_IDLE;
          waitCnt_next = '0;
        end
      end
      ST_IDLE: begin
        // A request taken here wins over a pending retention entry
        if (reqValid && reqReady_reg) begin
          pins_next.ceN       = 1'b0; // [RULE8]
          pins_next.addrLines = req.addr; // [RULE12]
          if (req.write) begin
            state_next   = ST_WR_SETUP;
            dataOut_next = req.data; // [RULE14]
            dataOe_next  = 1'b1; // [RULE19]
          end else begin
            state_next    = ST_READ;
            pins_next.oeN = 1'b0; // [RULE23]
            readCnt_next  = '0;
          end
        end else if (retainReq) begin
          state_next     = ST_RETAIN;
          retainAck_next = 1'b1; // [RULE21]
        end
      end
      ST_READ: begin
        // Strobes held low until data has crossed the synchroniser [RULE7]
        readCnt_next = readCnt_reg + 2'h1;
        if (readCnt_reg == READ_LAST) begin // [RULE2]
          pins_next.ceN = 1'b1;
          pins_next.oeN = 1'b1;
          rspValid_next = 1'b1;
          rspData_next  = dataSync;
          state_next    = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        pins_next.weN = 1'b0; // [RULE9]
        state_next    = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        // Write enable rise ends the write while select stays low
        pins_next.weN = 1'b1; // [RULE10] [RULE11]
        state_next    = ST_WR_END;
      end
      ST_WR_END: begin
        // Address and data released only with select
        pins_next.ceN = 1'b1; // [RULE13] [RULE15] [RULE16]
        dataOe_next   = 1'b0;
        state_next    = ST_IDLE;
      end
      ST_RETAIN: begin
        if (!retainReq) begin
          retainAck_next = 1'b0;
          waitCnt_next   = '0;
          state_next     = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        waitCnt_next = waitCnt_reg + 13'h0001;
        if (waitCnt_reg == RECOVERY_LAST) begin // [RULE22]
          state_next   = ST_IDLE;
          waitCnt_next = '0;
        end
      end
    endcase
    reqReady_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= ST_POWERUP;
      waitCnt_reg   <= '0;
      readCnt_reg   <= '0;
      pins_reg      <= ASBT_PINS_RESET;
      dataOut_reg   <= ASBT_DATA_RESET;
      dataOe_reg    <= 1'b0;
      reqReady_reg  <= 1'b0;
      rspValid_reg  <= 1'b0;
      rspData_reg   <= ASBT_DATA_RESET;
      retainAck_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      waitCnt_reg   <= waitCnt_next;
      readCnt_reg   <= readCnt_next;
      pins_reg      <= pins_next;
      dataOut_reg   <= dataOut_next;
      dataOe_reg    <= dataOe_next;
      reqReady_reg  <= reqReady_next;
      rspValid_reg  <= rspValid_next;
      rspData_reg   <= rspData_next;
      retainAck_reg <= retainAck_next;
    end
  end

  assign sramPins  = pins_reg;
  assign dataOut   = dataOut_reg;
  assign dataOe    = dataOe_reg;
  assign reqReady  = reqReady_reg;
  assign rspValid  = rspValid_reg;
  assign rspData   = rspData_reg;
  assign retainAck = retainAck_reg;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [ASBT_CNT_W-1:0] sinceReset_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sinceReset_reg <= '0;
    end else if (sinceReset_reg != 13'h1FFF) begin
      sinceReset_reg <= sinceReset_reg + 13'h0001;
    end
  end

  property p_powerup;
    !sramPins.ceN |-> sinceReset_reg >= ASBT_CNT_W'(POWERUP_CYCLES);
  endproperty
  a_powerup: assert property (p_powerup) else $error("access before power-up wait"); // [RULE1]

  property p_read_shape;
    $fell(sramPins.oeN) |-> (!sramPins.oeN && !sramPins.ceN && sramPins.weN)[*3]
                            ##1 (sramPins.oeN && rspValid);
  endproperty
  a_read_shape: assert property (p_read_shape) else $error("read strobes wrong"); // [RULE2]

  property p_read_addr;
    (!sramPins.ceN && !sramPins.oeN && !$fell(sramPins.ceN)) |-> $stable(sramPins.addrLines);
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("address moved in read"); // [RULE8]

  property p_write_overlap;
    !sramPins.weN |-> !sramPins.ceN && sramPins.oeN;
  endproperty
  a_write_overlap: assert property (p_write_overlap) else $error("write without select"); // [RULE9]

  property p_write_pulse;
    $fell(sramPins.weN) |-> $stable(sramPins.addrLines) && !$past(sramPins.ceN)
                            ##1 $rose(sramPins.weN) && !sramPins.ceN;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse wrong"); // [RULE11]

  property p_write_end;
    $rose(sramPins.weN) |-> $stable(sramPins.addrLines) && $stable(dataOut) && dataOe
                            && $past(dataOe, 2) ##1 sramPins.ceN && !dataOe;
  endproperty
  a_write_end: assert property (p_write_end) else $error("write end hold broken"); // [RULE14]

  property p_no_contention;
    dataOe |-> sramPins.oeN && $past(sramPins.oeN);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention"); // [RULE19]

  property p_retain;
    retainAck |-> sramPins.ceN && !reqReady;
  endproperty
  a_retain: assert property (p_retain) else $error("selected during retention"); // [RULE21]

  property p_recover;
    $fell(retainAck) |-> (!reqReady && sramPins.ceN)[*8];
  endproperty
  a_recover: assert property (p_recover) else $error("recovery wait skipped"); // [RULE22]

  property p_cov_write;
    $fell(sramPins.weN);
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_read;
    rspValid;
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_retain;
    $fell(retainAck);
  endproperty
  c_cov_retain: cover property (p_cov_retain);

  property p_cov_read_after_write;
    $rose(sramPins.weN) ##[1:6] $fell(sramPins.oeN);
  endproperty
  c_cov_read_after_write: cover property (p_cov_read_after_write);

endmodule : asbt_ctrl

/* asbt_pkg.sv */
// Constants, types and timing counts for the static memory host controller
package asbt_pkg;

  localparam int unsigned ASBT_ADDR_W          = 19;
  localparam int unsigned ASBT_DATA_W          = 8;
  localparam int unsigned ASBT_CNT_W           = 13;

  // Clock
  localparam int unsigned ASBT_CLK_PERIOD_NS   = 20;

  // Device timing, fast grade and slow grade
  localparam int unsigned ASBT_POWERUP_WAIT_US       = 100;
  localparam int unsigned ASBT_RETENTION_RECOVERY_US = 50;
  localparam int unsigned ASBT_READ_CYCLE_MIN_NS_F   = 10;
  localparam int unsigned ASBT_READ_CYCLE_MIN_NS_S   = 12;
  localparam int unsigned ASBT_WRITE_PULSE_MIN_NS_F  = 7;
  localparam int unsigned ASBT_WRITE_PULSE_MIN_NS_S  = 8;
  localparam int unsigned ASBT_DATA_SETUP_NS_F       = 5;
  localparam int unsigned ASBT_DATA_SETUP_NS_S       = 6;
  localparam int unsigned ASBT_SYNC_STAGES           = 2;

  // Slow grade figures are used so both grades are covered
  localparam int unsigned ASBT_POWERUP_WAIT_CYC =
    (ASBT_POWERUP_WAIT_US * 1000 + ASBT_CLK_PERIOD_NS - 1) / ASBT_CLK_PERIOD_NS;
  localparam int unsigned ASBT_READ_CYCLE_CYC =
    (ASBT_READ_CYCLE_MIN_NS_S + ASBT_CLK_PERIOD_NS - 1) / ASBT_CLK_PERIOD_NS;
  localparam int unsigned ASBT_WRITE_PULSE_CYC =
    (ASBT_WRITE_PULSE_MIN_NS_S + ASBT_CLK_PERIOD_NS - 1) / ASBT_CLK_PERIOD_NS;
  localparam int unsigned ASBT_DATA_SETUP_CYC =
    (ASBT_DATA_SETUP_NS_S + ASBT_CLK_PERIOD_NS - 1) / ASBT_CLK_PERIOD_NS;
  localparam int unsigned ASBT_RECOVERY_CYC =
    (ASBT_RETENTION_RECOVERY_US * 1000 + ASBT_CLK_PERIOD_NS - 1) / ASBT_CLK_PERIOD_NS
    + ASBT_READ_CYCLE_CYC;
  // Access cycle plus the input synchroniser depth
  localparam int unsigned ASBT_READ_HOLD_CYC = ASBT_READ_CYCLE_CYC + ASBT_SYNC_STAGES;

  typedef struct packed {
    logic                   write;
    logic [ASBT_ADDR_W-1:0] addr;
    logic [ASBT_DATA_W-1:0] data;
  } asbt_req_s;

  typedef struct packed {
    logic                   ceN;
    logic                   oeN;
    logic                   weN;
    logic [ASBT_ADDR_W-1:0] addrLines;
  } asbt_pins_s;

  localparam asbt_pins_s ASBT_PINS_RESET = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
                                             addrLines: 19'h00000};
  localparam logic [ASBT_DATA_W-1:0] ASBT_DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_READ,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RETAIN,
    ST_RECOVER
  } asbt_state_e;

endpackage : asbt_pkg

/* asbt_sync.sv */
// Two-flop synchroniser for the memory data lines
`timescale 1ns/1ns
module asbt_sync
  import asbt_pkg::*;
(
  // Clock and reset
  input  logic                   clock,
  input  logic                   resetn,
  // Data
  input  logic [ASBT_DATA_W-1:0] dataAsync,
  output logic [ASBT_DATA_W-1:0] dataSync
);

  logic [ASBT_DATA_W-1:0] stage1_reg;
  logic [ASBT_DATA_W-1:0] stage2_reg;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= ASBT_DATA_RESET;
      stage2_reg <= ASBT_DATA_RESET;
    end else begin
      stage1_reg <= dataAsync;
      stage2_reg <= stage1_reg;
    end
  end

  assign dataSync = stage2_reg;

endmodule : asbt_sync

/* asbt_mem_model.sv */
// Behavioural model of the static memory device on the far side of the controller
`timescale 1ns/1ns
module asbt_mem_model
  import asbt_pkg::*;
#(
  parameter int unsigned ACCESS_NS = 6
) (
  // Memory pins from the controller
  input  asbt_pkg::asbt_pins_s   pins,
  input  logic [ASBT_DATA_W-1:0] hostData,
  input  logic                   hostOe,
  // Resolved data lines and contention count
  output logic [ASBT_DATA_W-1:0] busLevel,
  output int                     clashCount
);
  import asbt_pkg::*;

  logic [ASBT_DATA_W-1:0] mem [logic [ASBT_ADDR_W-1:0]];
  logic [ASBT_DATA_W-1:0] devData;
  logic                   devOe;
  logic                   readMode;
  logic                   writing;

  function automatic logic [ASBT_DATA_W-1:0] lookup(input logic [ASBT_ADDR_W-1:0] a);
    // Unwritten bytes return an address-derived pattern, never a stale value
    return mem.exists(a) ? mem[a] : ~a[7:0];
  endfunction : lookup

  initial begin
    devOe = 1'b0;
    devData = 8'h00;
    busLevel = 8'h00;
    clashCount = 0;
  end

  assign readMode = !pins.ceN && !pins.oeN && pins.weN;
  assign writing  = !pins.ceN && !pins.weN;

  // Drive after the access time, float almost at once
  always @(readMode) begin
    devOe <= #(readMode ? ACCESS_NS : 1) readMode;
  end

  // Old byte stays on the lines for the access time after an address change
  always @(pins.addrLines or readMode) begin
    devData <= #ACCESS_NS lookup(pins.addrLines);
  end

  // Store at the end of the select and write-enable overlap
  always @(negedge writing) begin
    mem[pins.addrLines] = busLevel;
  end

  always @(posedge (hostOe && devOe)) begin
    clashCount++;
  end

  // Released lines with no pull show the inverse of the last level
  always @(hostOe or devOe or hostData or devData) begin
    if (hostOe) begin
      busLevel = hostData;
    end else if (devOe) begin
      busLevel = devData;
    end else begin
      busLevel = ~busLevel;
    end
  end
endmodule : asbt_mem_model

/* tb_top.sv */
// Self-checking testbench for the static memory host controller
`timescale 1ns/1ns
module tb_top;
  import asbt_pkg::*;

  localparam int unsigned PWR = 8;

  logic                   clock;
  logic                   resetn;
  logic                   reqValid;
  logic                   reqReady;
  logic                   rspValid;
  logic                   retainReq;
  logic                   retainAck;
  logic                   dataOe;
  asbt_req_s              req;
  asbt_pins_s             sramPins;
  logic [ASBT_DATA_W-1:0] rspData;
  logic [ASBT_DATA_W-1:0] dataOut;
  logic [ASBT_DATA_W-1:0] dataIn;
  int                     clashCount;
  int                     strobeFaults;
  int                     bad_count;
  int                     samples_checked;

  asbt_ctrl #(.POWERUP_CYCLES(PWR)) asbt_ctrl_i (
    .clock(clock), .resetn(resetn), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .retainReq(retainReq), .retainAck(retainAck),
    .sramPins(sramPins), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn)
  );

  asbt_mem_model asbt_mem_model_i (
    .pins(sramPins), .hostData(dataOut), .hostOe(dataOe), .busLevel(dataIn),
    .clashCount(clashCount)
  );

  initial clock = 1'b0;
  always #10 clock = ~clock;

  // Strobe order faults seen at the pins
  always @(posedge clock) begin
    if (resetn && ((sramPins.weN === 1'b0 && sramPins.ceN !== 1'b0) ||
                   (dataOe === 1'b1 && sramPins.oeN !== 1'b1))) begin
      strobeFaults++;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Present one request and return just after the edge that takes it
  task automatic issue(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int n;
    reqValid = 1'b1;
    req = '{write: wr, addr: a, data: d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    #1 reqValid = 1'b0;
    check("reqTaken", n < 50, 1);
  endtask : issue

  task automatic write_byte(input logic [18:0] a, input logic [7:0] d);
    issue(1'b1, a, d);
    @(posedge clock);
    #1 check("writePins", {sramPins.ceN, sramPins.weN, sramPins.addrLines}, {2'b00, a});
    check("writeData", {dataOe, dataOut}, {1'b1, d});
    @(posedge clock);
    #1;
  endtask : write_byte

  task automatic read_byte(input logic [18:0] a, input logic [7:0] d);
    issue(1'b0, a, 8'h00);
    @(posedge clock);
    #1 check("readPins", {sramPins.ceN, sramPins.oeN, sramPins.weN, sramPins.addrLines},
             {3'b001, a});
    @(posedge clock);
    #1 check("rspEarly", rspValid, 0);
    @(posedge clock);
    #1 check("rspData", {rspValid, rspData}, {1'b1, d});
  endtask : read_byte

  task automatic test_powerup;
    check("resetPins", sramPins, ASBT_PINS_RESET);
    @(posedge clock);
    #1 resetn = 1'b1;
    repeat (PWR - 1) @(posedge clock);
    #1 check("earlyReady", reqReady, 0);
    @(posedge clock);
    #1 check("readyAfterWait", reqReady, 1);
  endtask : test_powerup

  task automatic test_data;
    logic [18:0] addrs [4] = '{19'h00000, 19'h7FFFF, 19'h12345, 19'h55555};
    logic [7:0]  bytes [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    foreach (addrs[i]) write_byte(addrs[i], bytes[i]);
    write_byte(19'h12345, 8'h3C);
    bytes[2] = 8'h3C;
    foreach (addrs[i]) read_byte(addrs[i], bytes[i]);
  endtask : test_data

  task automatic test_retention;
    int n;
    retainReq = 1'b1;
    @(posedge clock);
    #1 check("retainAck", {retainAck, reqReady, sramPins.ceN}, 3'b101);
    repeat (20) @(posedge clock);
    #1 retainReq = 1'b0;
    @(posedge clock);
    #1 check("retainDrop", retainAck, 0);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (reqReady !== 1'b1 && n < 3000);
    check("recoveryCycles", n, ASBT_RECOVERY_CYC);
    read_byte(19'h12345, 8'h3C);
  endtask : test_retention

  initial begin
    resetn = 1'b0;
    reqValid = 1'b0;
    retainReq = 1'b0;
    req = '0;
    bad_count = 0;
    samples_checked = 0;
    strobeFaults = 0;
    repeat (11) @(posedge clock);
    test_powerup();
    test_data();
    test_retention();
    check("busClash", clashCount, 0);
    check("strobeOrder", strobeFaults, 0);
    report_and_stop();
  end

  // Run needs about 3000 cycles; five times that marks a hang
  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top
